// ### hw/cpu_regs_regs.svh
// Constants for the CPU register file and operand decode
`ifndef CPU_REGS_REGS_SVH
`define CPU_REGS_REGS_SVH
`define REG_IP 4'h0
`define REG_SP 4'h1
`define REG_FW 4'h2
`define REG_CG 4'h3
`define FW_C 0
`define FW_Z 1
`define FW_N 2
`define FW_GIE 3
`define FW_HALT 4
`define FW_XTAL 5
`define FW_DCGEN 6
`define FW_SUBCLK 7
`define FW_V 8
`define FW_RESET 16'h0000
`define SP_RESET 16'h0000
`define IP_RESET 16'h0000
`define ADDR_RD 4'h0
`define ADDR_WR 4'h1
`define ADDR_FW 4'h2
`define ADDR_IDX 4'h3
`define CONST_4 16'h0004
`define CONST_8 16'h0008
`define CONST_0 16'h0000
`define CONST_1 16'h0001
`define CONST_2 16'h0002
`define CONST_M1 16'hFFFF
`endif

// ### hw/cpu_regs_pkg.sv
// Types for the CPU register file
package cpu_regs_pkg;
  typedef enum logic [1:0] {
    AM_REG,
    AM_INDEXED,
    AM_INDIRECT,
    AM_AUTOINC
  } src_mode_e;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD,
    OP_SUB,
    OP_LOGIC
  } alu_kind_e;
  typedef struct packed {
    logic [3:0] reg_idx;
    logic [1:0] source_mode_field;
    logic byte_op;
  } src_sel_s;
  typedef struct packed {
    logic valid;
    logic [3:0] reg_idx;
    logic byte_op;
    logic [15:0] data;
  } reg_wr_s;
  typedef struct packed {
    logic valid;
    alu_kind_e kind;
    logic byte_op;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic [16:0] result;
  } flag_upd_s;
endpackage

// ### hw/cpu_register_file.sv
// Sixteen-entry CPU register file with operand mode decode
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_regs.svh"
module cpu_register_file (
  input wire logic clock,
  input wire logic arst_n,
  input wire cpu_regs_pkg::src_sel_s src_sel,
  input wire logic [15:0] src_ext_word,
  input wire logic src_done,
  input wire cpu_regs_pkg::reg_wr_s reg_wr,
  input wire cpu_regs_pkg::flag_upd_s flag_upd,
  input wire logic instr_done,
  input wire logic [2:0] instr_len,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic pop_to_sp,
  input wire logic [15:0] pop_data,
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_write,
  input wire logic sw_read,
  input wire logic dco_feeds_clock,
  input wire logic xtal_feeds_clock,
  input wire logic irq_pending,
  output logic [15:0] sw_rdata,
  output logic [15:0] src_operand,
  output logic [15:0] src_address,
  output logic src_is_addr,
  output logic src_needs_word,
  output logic [15:0] instr_pointer_out,
  output logic [15:0] stack_pointer_out,
  output logic subsystem_clock_off,
  output logic dc_gen_off,
  output logic crystal_off,
  output logic cpu_halted,
  output logic irq_take
);
  logic [15:0] regs_q [4:15];
  logic [15:0] instr_pointer_q;
  logic [15:0] stack_pointer_q;
  logic [15:0] flag_word_q;
  logic [15:0] sel_reg;
  logic [15:0] step;
  logic [15:0] wr_val;
  logic [16:0] res;
  logic sign_r;
  logic sign_a;
  logic sign_b;
  logic ovf;
  logic [15:0] flags_d;
  logic [3:0] sw_reg;
  cpu_regs_pkg::src_mode_e mode;

  // Byte writes zero the upper half
  always_comb begin
    wr_val = reg_wr.byte_op ? {8'h00, reg_wr.data[7:0]} : reg_wr.data;
  end

  always_comb begin
    mode = cpu_regs_pkg::src_mode_e'(src_sel.source_mode_field);
  end

  // Register read for the source operand
  always_comb begin
    unique case (src_sel.reg_idx)
      `REG_IP: sel_reg = instr_pointer_q;
      `REG_SP: sel_reg = stack_pointer_q;
      `REG_FW: sel_reg = flag_word_q;
      `REG_CG: sel_reg = `CONST_0;
      default: sel_reg = regs_q[src_sel.reg_idx];
    endcase
  end

  // Autoincrement step; stack and pointer stay even so always two there
  always_comb begin
    if (src_sel.byte_op && src_sel.reg_idx != `REG_IP && src_sel.reg_idx != `REG_SP) begin
      step = 16'h0001;
    end else begin
      step = 16'h0002;
    end
  end

  // Operand decode registered toward the datapath
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      src_operand <= 16'h0000;
      src_address <= 16'h0000;
      src_is_addr <= 1'b0;
      src_needs_word <= 1'b0;
    end else begin
      src_is_addr <= 1'b0;
      src_needs_word <= 1'b0;
      src_address <= 16'h0000;
      src_operand <= sel_reg;
      if (src_sel.reg_idx == `REG_CG) begin
        unique case (mode)
          cpu_regs_pkg::AM_REG: src_operand <= `CONST_0;
          cpu_regs_pkg::AM_INDEXED: src_operand <= `CONST_1;
          cpu_regs_pkg::AM_INDIRECT: src_operand <= `CONST_2;
          cpu_regs_pkg::AM_AUTOINC: src_operand <= `CONST_M1;
        endcase
      end else if (src_sel.reg_idx == `REG_FW && mode != cpu_regs_pkg::AM_REG) begin
        unique case (mode)
          cpu_regs_pkg::AM_INDEXED: begin
            src_address <= src_ext_word;
            src_is_addr <= 1'b1;
            src_needs_word <= 1'b1;
          end
          cpu_regs_pkg::AM_INDIRECT: src_operand <= `CONST_4;
          default: src_operand <= `CONST_8;
        endcase
      end else begin
        unique case (mode)
          cpu_regs_pkg::AM_REG: src_operand <= sel_reg;
          cpu_regs_pkg::AM_INDEXED: begin
            src_address <= sel_reg + src_ext_word;
            src_is_addr <= 1'b1;
            src_needs_word <= 1'b1;
          end
          cpu_regs_pkg::AM_INDIRECT: begin
            src_address <= sel_reg;
            src_is_addr <= 1'b1;
          end
          cpu_regs_pkg::AM_AUTOINC: begin
            src_address <= sel_reg;
            src_is_addr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Instruction pointer; datapath writes win as branches
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      instr_pointer_q <= `IP_RESET;
    end else if (reg_wr.valid && reg_wr.reg_idx == `REG_IP) begin
      instr_pointer_q <= {wr_val[15:1], 1'b0};
    end else if (sw_write && sw_addr == `ADDR_WR && sw_wdata[3:0] == `REG_IP) begin
      instr_pointer_q <= instr_pointer_q;
    end else if (src_done && src_sel.reg_idx == `REG_IP && mode == cpu_regs_pkg::AM_AUTOINC) begin
      instr_pointer_q <= instr_pointer_q + 16'h0002;
    end else if (instr_done && !flag_word_q[`FW_HALT]) begin
      instr_pointer_q <= instr_pointer_q + {12'h000, instr_len, 1'b0};
    end
  end

  // Stack pointer; loads clear bit 0 and every step is two so it stays even
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stack_pointer_q <= `SP_RESET;
    end else if (pop_req && pop_to_sp) begin
      stack_pointer_q <= {pop_data[15:1], 1'b0};
    end else if (reg_wr.valid && reg_wr.reg_idx == `REG_SP) begin
      stack_pointer_q <= {wr_val[15:1], 1'b0};
    end else if (push_req) begin
      stack_pointer_q <= stack_pointer_q - 16'h0002;
    end else if (pop_req) begin
      stack_pointer_q <= stack_pointer_q + 16'h0002;
    end else if (src_done && src_sel.reg_idx == `REG_SP && mode == cpu_regs_pkg::AM_AUTOINC) begin
      stack_pointer_q <= stack_pointer_q + 16'h0002;
    end
  end

  // General-purpose registers, one slice per entry
  for (genvar g = 4; g < 16; g++) begin : gp
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        regs_q[g] <= 16'h0000;
      end else if (reg_wr.valid && reg_wr.reg_idx == 4'(g)) begin
        regs_q[g] <= wr_val;
      end else if (src_done && src_sel.reg_idx == 4'(g) && mode == cpu_regs_pkg::AM_AUTOINC) begin
        regs_q[g] <= regs_q[g] + step;
      end
    end
  end

  // Flag computation from the datapath result
  always_comb begin
    res = flag_upd.result;
    sign_r = flag_upd.byte_op ? res[7] : res[15];
    sign_a = flag_upd.byte_op ? flag_upd.op_a[7] : flag_upd.op_a[15];
    sign_b = flag_upd.byte_op ? flag_upd.op_b[7] : flag_upd.op_b[15];
    unique case (flag_upd.kind)
      cpu_regs_pkg::OP_ADD: ovf = (sign_a == sign_b) && (sign_r != sign_a);
      cpu_regs_pkg::OP_SUB: ovf = (sign_a != sign_b) && (sign_r != sign_a);
      default: ovf = 1'b0;
    endcase
    flags_d = flag_word_q;
    flags_d[`FW_N] = sign_r;
    flags_d[`FW_Z] = flag_upd.byte_op ? (res[7:0] == 8'h00) : (res[15:0] == 16'h0000);
    flags_d[`FW_C] = flag_upd.byte_op ? res[8] : res[16];
    flags_d[`FW_V] = ovf;
  end

  // Flag word: of the datapath writes only word ones reach it; debug writes and flag updates also load it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_word_q <= `FW_RESET;
    end else if (reg_wr.valid && reg_wr.reg_idx == `REG_FW && !reg_wr.byte_op) begin
      flag_word_q <= reg_wr.data;
    end else if (sw_write && sw_addr == `ADDR_FW) begin
      flag_word_q <= sw_wdata;
    end else if (flag_upd.valid && flag_upd.kind != cpu_regs_pkg::OP_NONE) begin
      flag_word_q <= flags_d;
    end
  end

  // Clock and CPU control outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      subsystem_clock_off <= 1'b0;
      dc_gen_off <= 1'b0;
      crystal_off <= 1'b0;
      cpu_halted <= 1'b0;
      irq_take <= 1'b0;
    end else begin
      subsystem_clock_off <= flag_word_q[`FW_SUBCLK];
      dc_gen_off <= flag_word_q[`FW_DCGEN] && !dco_feeds_clock;
      crystal_off <= flag_word_q[`FW_XTAL] && !xtal_feeds_clock;
      cpu_halted <= flag_word_q[`FW_HALT];
      irq_take <= irq_pending && flag_word_q[`FW_GIE];
    end
  end

  // Pointer copies for the fetch and stack address paths
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      instr_pointer_out <= 16'h0000;
      stack_pointer_out <= 16'h0000;
    end else begin
      instr_pointer_out <= instr_pointer_q;
      stack_pointer_out <= stack_pointer_q;
    end
  end

  // Debug read port; index register picks which entry is read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sw_reg <= 4'h0;
    end else if (sw_write && sw_addr == `ADDR_IDX) begin
      sw_reg <= sw_wdata[3:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sw_rdata <= 16'h0000;
    end else if (sw_read) begin
      unique case (sw_addr)
        `ADDR_FW: sw_rdata <= flag_word_q;
        `ADDR_IDX: sw_rdata <= {12'h000, sw_reg};
        `ADDR_RD: begin
          unique case (sw_reg)
            `REG_IP: sw_rdata <= instr_pointer_q;
            `REG_SP: sw_rdata <= stack_pointer_q;
            `REG_FW: sw_rdata <= flag_word_q;
            `REG_CG: sw_rdata <= 16'h0000;
            default: sw_rdata <= regs_q[sw_reg];
          endcase
        end
        default: sw_rdata <= 16'h0000;
      endcase
    end else begin
      sw_rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ### testbench/cpu_regs_properties.sv
// Port assertions for the register file
`timescale 1ns/1ps
`default_nettype none
module cpu_regs_properties (
  input wire logic clock,
  input wire logic arst_n,
  input wire cpu_regs_pkg::src_sel_s src_sel,
  input wire cpu_regs_pkg::reg_wr_s reg_wr,
  input wire logic src_done,
  input wire logic instr_done,
  input wire logic [2:0] instr_len,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic pop_to_sp,
  input wire logic [15:0] pop_data,
  input wire logic xtal_feeds_clock,
  input wire logic irq_pending,
  input wire logic [15:0] src_operand,
  input wire logic [15:0] instr_pointer_out,
  input wire logic [15:0] stack_pointer_out,
  input wire logic crystal_off,
  input wire logic cpu_halted,
  input wire logic irq_take
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Push and step pointer checks only hold with no competing writer
  wire logic quiet = !reg_wr.valid && !src_done;
  const_m1_a: assert property (
    src_sel.reg_idx == 4'h3 && src_sel.source_mode_field == 2'h3 |=> src_operand == 16'hFFFF)
    else $error("bad minus one");
  sp_even_a: assert property (
    stack_pointer_out[0] == 1'b0) else $error("odd stack pointer");
  push_dec_a: assert property (
    push_req && !pop_req && quiet |-> ##2 stack_pointer_out == $past(stack_pointer_out) - 16'h0002)
    else $error("bad push");
  pop_self_a: assert property (
    pop_req && pop_to_sp |-> ##2 stack_pointer_out == ($past(pop_data, 2) & 16'hFFFE))
    else $error("bad self pop");
  ip_step_a: assert property (
    instr_done && !cpu_halted && quiet |-> ##2
    instr_pointer_out == $past(instr_pointer_out) + {12'h000, $past(instr_len, 2), 1'b0})
    else $error("bad step");
  ip_halt_a: assert property (
    instr_done && cpu_halted && quiet |-> ##2 $stable(instr_pointer_out)) else $error("halted step");
  irq_gate_a: assert property (
    !irq_pending |=> !irq_take) else $error("spurious take");
  xtal_gate_a: assert property (
    xtal_feeds_clock |=> !crystal_off) else $error("crystal cut in use");
endmodule
bind cpu_register_file cpu_regs_properties cpu_regs_properties_inst (.clock, .arst_n, .src_sel, .reg_wr,
  .src_done, .instr_done, .instr_len, .push_req, .pop_req, .pop_to_sp, .pop_data, .xtal_feeds_clock,
  .irq_pending, .src_operand, .instr_pointer_out, .stack_pointer_out, .crystal_off, .cpu_halted, .irq_take);
`default_nettype wire

// ### testbench/alu_model.sv
// Datapath model producing flag updates
`timescale 1ns/1ps
`default_nettype none
module alu_model (
  input wire logic clock,
  input wire logic go,
  input wire cpu_regs_pkg::alu_kind_e kind,
  input wire logic byte_op,
  input wire logic [15:0] op_a,
  input wire logic [15:0] op_b,
  output var cpu_regs_pkg::flag_upd_s flag_upd
);
  initial flag_upd = '0;
  // Subtract is a plus inverted b plus one; byte subtracts not modelled
  always @(posedge clock) begin
    flag_upd <= {go, kind, byte_op, op_a, op_b, (kind == cpu_regs_pkg::OP_SUB) ?
      {1'b0, op_a} + {1'b0, ~op_b} + 17'h00001 : {1'b0, op_a} + {1'b0, op_b}};
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the register file
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = '0, arst_n = '0;
  cpu_regs_pkg::src_sel_s src_sel = '0;
  cpu_regs_pkg::reg_wr_s reg_wr = '0;
  cpu_regs_pkg::flag_upd_s flag_upd;
  cpu_regs_pkg::alu_kind_e kind = cpu_regs_pkg::OP_ADD;
  logic [15:0] src_ext_word = '0, pop_data = '0, sw_wdata = '0, op_a = '0, op_b = '0, v;
  logic [15:0] sw_rdata, src_operand, src_address, instr_pointer_out, stack_pointer_out, rq[$], sq[$];
  logic [3:0] sw_addr = '0;
  logic [2:0] instr_len = '0;
  logic src_done = '0, instr_done = '0, push_req = '0, pop_req = '0, pop_to_sp = '0, sw_write = '0;
  logic sw_read = '0, dco_feeds_clock = '0, xtal_feeds_clock = '1, irq_pending = '0, go = '0, byte_op = '0;
  logic src_is_addr, src_needs_word, subsystem_clock_off, dc_gen_off, crystal_off, cpu_halted, irq_take;
  logic src_chk = '0, rd_d = '0, sc_d = '0;
  logic [31:0] seed = 32'h00000059;
  int err_count = 0, samples_checked = 0, cycles = 0;
  cpu_register_file cpu_register_file_inst (.clock, .arst_n, .src_sel, .src_ext_word, .src_done, .reg_wr,
    .flag_upd, .instr_done, .instr_len, .push_req, .pop_req, .pop_to_sp, .pop_data, .sw_addr, .sw_wdata,
    .sw_write, .sw_read, .dco_feeds_clock, .xtal_feeds_clock, .irq_pending, .sw_rdata, .src_operand,
    .src_address, .src_is_addr, .src_needs_word, .instr_pointer_out, .stack_pointer_out,
    .subsystem_clock_off, .dc_gen_off, .crystal_off, .cpu_halted, .irq_take);
  alu_model alu_model_inst (.clock, .go, .kind, .byte_op, .op_a, .op_b, .flag_upd);
  initial forever #2 clock = ~clock;
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Ends every strobe one cycle after it was raised
  task automatic tick;
    @(posedge clock);
    {sw_write, sw_read, reg_wr.valid, src_done, src_chk} <= '0;
    {instr_done, push_req, pop_req, pop_to_sp, go} <= '0;
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clock);
    {sw_addr, sw_wdata, sw_write} <= {a, d, 1'b1};
    tick;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clock);
    {sw_addr, sw_read} <= {a, 1'b1};
    rq.push_back(e);
    tick;
  endtask
  task automatic rr(logic [3:0] n, logic [15:0] e);
    wr(4'h3, {12'h000, n});
    rd(4'h0, e);
  endtask
  task automatic rw(logic [3:0] n, logic b, logic [15:0] d);
    @(posedge clock);
    reg_wr <= {1'b1, n, b, d};
    tick;
  endtask
  task automatic src(logic [3:0] n, logic [1:0] m, logic b, logic d, logic c, logic [15:0] e);
    @(posedge clock);
    {src_sel, src_done, src_chk} <= {n, m, b, d, c};
    if (c) sq.push_back(e);
    tick;
  endtask
  task automatic stk(logic p, logic q, logic t, logic [15:0] d);
    @(posedge clock);
    {push_req, pop_req, pop_to_sp, pop_data} <= {p, q, t, d};
    tick;
  endtask
  task automatic step(logic [2:0] l);
    @(posedge clock);
    {instr_done, instr_len} <= {1'b1, l};
    tick;
  endtask
  task automatic alu(cpu_regs_pkg::alu_kind_e k, logic b, logic [15:0] x, logic [15:0] y, logic [15:0] e);
    @(posedge clock);
    {kind, byte_op, op_a, op_b, go} <= {k, b, x, y, 1'b1};
    tick;
    rd(4'h2, e);
  endtask
  always @(posedge clock) begin
    rd_d <= sw_read;
    sc_d <= src_chk;
    if (rd_d) chk("sw_rdata", rq.pop_front(), sw_rdata);
    if (sc_d) chk("src_operand", sq.pop_front(), src_operand);
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= '1;
    rd(4'h2, 16'h0000);
    rr(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    $display("reset test done");
    for (int n = 4; n < 16; n++) begin
      v = rnd();
      rw(n[3:0], '0, v);
      rr(n[3:0], v);
      rw(n[3:0], '1, v);
      rr(n[3:0], {8'h00, v[7:0]});
    end
    rw(4'h3, '0, 16'h1234);
    rr(4'h3, 16'h0000);
    rw(4'h2, '1, 16'h00FF);
    rd(4'h2, 16'h0000);
    rw(4'h2, '0, 16'h0100);
    src(4'h2, 2'h0, '0, '0, '1, 16'h0100);
    src_ext_word <= 16'h0246;
    src(4'h2, 2'h1, '0, '0, '0, 16'h0000);
    @(negedge clock);
    chk("src_address", 16'h0246, src_address);
    chk("src_is_addr", 16'h0001, src_is_addr);
    chk("src_needs_word", 16'h0001, src_needs_word);
    src(4'h2, 2'h2, '0, '0, '1, 16'h0004);
    src(4'h2, 2'h3, '0, '0, '1, 16'h0008);
    for (int m = 0; m < 4; m++) src(4'h3, m[1:0], '0, '0, '1, m == 3 ? 16'hFFFF : 16'(m));
    $display("register test done");
    rw(4'h5, '0, 16'h1000);
    src(4'h5, 2'h3, '1, '1, '0, 16'h0000);
    rr(4'h5, 16'h1001);
    src(4'h5, 2'h3, '0, '1, '0, 16'h0000);
    src(4'h5, 2'h2, '0, '1, '0, 16'h0000);
    rr(4'h5, 16'h1003);
    src(4'h0, 2'h3, '0, '1, '0, 16'h0000);
    rr(4'h0, 16'h0002);
    for (int l = 1; l < 4; l++) step(l[2:0]);
    rr(4'h0, 16'h000E);
    rw(4'h0, '0, 16'h4000);
    rr(4'h0, 16'h4000);
    rw(4'h1, '0, 16'h0400);
    stk('1, '0, '0, 16'h0000);
    rr(4'h1, 16'h03FE);
    stk('1, '0, '0, 16'h0000);
    rr(4'h1, 16'h03FC);
    stk('0, '1, '0, 16'h0000);
    stk('0, '1, '1, 16'h1235);
    rr(4'h1, 16'h1234);
    $display("pointer test done");
    alu(cpu_regs_pkg::OP_ADD, '0, 16'h7FFF, 16'h0001, 16'h0104);
    alu(cpu_regs_pkg::OP_SUB, '0, 16'h8000, 16'h0001, 16'h0101);
    alu(cpu_regs_pkg::OP_ADD, '1, 16'h0080, 16'h0080, 16'h0103);
    alu(cpu_regs_pkg::OP_SUB, '0, 16'h0005, 16'h0005, 16'h0003);
    $display("flag test done");
    irq_pending <= '1;
    wr(4'h2, 16'h00F8);
    step(3'h1);
    rr(4'h0, 16'h4000);
    chk("subsystem_clock_off", 16'h0001, subsystem_clock_off);
    chk("dc_gen_off", 16'h0001, dc_gen_off);
    chk("crystal_off", 16'h0000, crystal_off);
    chk("cpu_halted", 16'h0001, cpu_halted);
    chk("irq_take", 16'h0001, irq_take);
    {xtal_feeds_clock, dco_feeds_clock} <= 2'h1;
    wr(4'h2, 16'h00F0);
    rd(4'h2, 16'h00F0);
    chk("crystal_off", 16'h0001, crystal_off);
    chk("dc_gen_off", 16'h0000, dc_gen_off);
    chk("irq_take", 16'h0000, irq_take);
    repeat (3) @(posedge clock);
    $display("control test done");
    end_of_test;
  end
endmodule
`default_nettype wire
